// ===== mac_datapath.sv
// Purpose: execution datapath with mac unit, accumulator window and dsp configuration
// Assumes: wishbone classic slave, sfr index = adr_i[9:2], data in bits 7:0
// Notes: instructions enter via the command sfr; the core decodes prefix and opcode
//   the mac result is built over nine cycles from four signed-aware 8x8 partial products
//
// Our own choice: the Wishbone register port.

module mac_datapath (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic compat_fuse_i,
  input wire logic ext_mem_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic fetch_en_o,
  output logic mcycle_end_o,
  output logic busy_o,
  output logic ring_enable_ptr0_o,
  output logic ring_enable_ptr1_o,
  output logic code_index_disable_o,
  output logic ptr1_redirect_b_o
);
  typedef enum logic [4:0] {
    st_idle = 5'b00001,
    st_prefix = 5'b00010,
    st_mac = 5'b00100,
    st_short = 5'b01000,
    st_done = 5'b10000
  } exec_state_t;

  typedef enum logic [1:0] {
    sop_clr = 2'h0,
    sop_lsl = 2'h1,
    sop_asr = 2'h2,
    sop_mul = 2'h3
  } short_op_t;

  typedef struct packed {
    exec_state_t st;
    short_op_t sop;
    logic [3:0] cnt;
    logic [7:0] acc_a;
    logic [7:0] reg_b;
    logic [7:0] opa_high;
    logic [7:0] opb_high;
    logic [7:0] cfg;
    logic [39:0] m_acc;
    logic [39:0] prod;
    logic [15:0] mul_res;
    logic carry;
    logic wrap;
    logic ack;
    logic [7:0] rdata;
    logic [7:0] next_op;
    logic next_valid;
    logic fuse_meta;
    logic fuse_sync;
  } dp_state_t;

  dp_state_t s_r, s_nxt;
  logic [7:0] sfr;
  logic req;
  logic wr_lane;
  logic [7:0] wbyte;
  logic [7:0] ma, mb;
  logic msa, msb;
  logic [17:0] mprod;
  logic [39:0] sum;
  logic [4:0] pp_sh;
  logic [1:0] win;
  logic [2:0] wlo;
  logic compat_mode;

  // byte of the accumulator by index
  function automatic logic [7:0] acc_byte(input logic [39:0] m, input logic [2:0] idx);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 5; i++)
      if (idx == 3'(i))
        r = m[i*8 +: 8];
    return r;
  endfunction

  // write one accumulator byte, the others kept
  function automatic logic [39:0] acc_put(input logic [39:0] m, input logic [2:0] idx,
                                          input logic [7:0] v);
    logic [39:0] r;
    r = m;
    for (int i = 0; i < 5; i++)
      if (idx == 3'(i))
        r[i*8 +: 8] = v;
    return r;
  endfunction

  // the fuse is sampled off the core clock, so it passes two flops first
  assign compat_mode = s_r.fuse_sync;

  fetch_pacer u_pacer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .compat_i(compat_mode),
    .ext_mem_i(ext_mem_i),
    .fetch_en_o(fetch_en_o),
    .state_tick_o(),
    .mcycle_end_o(mcycle_end_o)
  );

  mult8 u_mult (
    .a_i(ma),
    .b_i(mb),
    .sa_i(msa),
    .sb_i(msb),
    .p_o(mprod)
  );

  assign sfr = adr_i[9:2];
  assign req = cyc_i && stb_i && !s_r.ack;
  assign wr_lane = req && we_i && sel_i[0];
  assign wbyte = dat_i[7:0];
  assign win = s_r.cfg[dsp_pkg::cfg_win_msb:dsp_pkg::cfg_win_lsb];
  // window n starts at byte n, so 11 reaches the top byte
  assign wlo = {1'b0, win};

  // partial product select, step 0..3 of the mac or byte multiply
  always_comb
  begin
    // byte offset of the partial product; a 1-bit sum would wrap the high-by-high step to offset 0 instead of 16
    pp_sh = {{1'b0, s_r.cnt[1]} + {1'b0, s_r.cnt[0]}, 3'b000};
    ma = s_r.acc_a;
    mb = s_r.reg_b;
    msa = s_r.cfg[dsp_pkg::cfg_signed_a];
    msb = s_r.cfg[dsp_pkg::cfg_signed_b];
    if (s_r.st == st_mac)
    begin
      // low bytes unsigned, high bytes signed regardless of config
      ma = s_r.cnt[0] ? s_r.opa_high : s_r.acc_a;
      mb = s_r.cnt[1] ? s_r.opb_high : s_r.reg_b;
      msa = s_r.cnt[0];
      msb = s_r.cnt[1];
    end
  end

  assign sum = s_r.m_acc + s_r.prod;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    // two-flop synchroniser for the mode fuse
    s_nxt.fuse_meta = compat_fuse_i;
    s_nxt.fuse_sync = s_r.fuse_meta;
    // bus access
    if (req)
    begin
      s_nxt.ack = 1'b1;
      s_nxt.rdata = 8'h00;
      if (sfr == dsp_pkg::sfr_acc)
        s_nxt.rdata = s_r.acc_a;
      else if (sfr == dsp_pkg::sfr_opa_high)
        s_nxt.rdata = s_r.opa_high;
      else if (sfr == dsp_pkg::sfr_dsp_config)
        s_nxt.rdata = s_r.cfg;
      else if (sfr == dsp_pkg::sfr_win_low)
        s_nxt.rdata = acc_byte(s_r.m_acc, wlo);
      else if (sfr == dsp_pkg::sfr_win_high)
        s_nxt.rdata = acc_byte(s_r.m_acc, wlo + 3'h1);
      else if (sfr == dsp_pkg::sfr_b)
        s_nxt.rdata = s_r.reg_b;
      else if (sfr == dsp_pkg::sfr_opb_high)
        s_nxt.rdata = s_r.opb_high;
      else if (sfr == dsp_pkg::sfr_status)
        s_nxt.rdata = {s_r.carry, 4'h0, s_r.wrap, 1'b0, busy_o};
      else if (sfr == dsp_pkg::sfr_prod_low)
        s_nxt.rdata = s_r.mul_res[7:0];
      else if (sfr == dsp_pkg::sfr_prod_high)
        s_nxt.rdata = s_r.mul_res[15:8];
      if (wr_lane)
      begin
        if (sfr == dsp_pkg::sfr_acc)
          s_nxt.acc_a = wbyte;
        else if (sfr == dsp_pkg::sfr_opa_high)
          s_nxt.opa_high = wbyte;
        else if (sfr == dsp_pkg::sfr_dsp_config)
          s_nxt.cfg = wbyte;
        else if (sfr == dsp_pkg::sfr_win_low)
          s_nxt.m_acc = acc_put(s_r.m_acc, wlo, wbyte);
        else if (sfr == dsp_pkg::sfr_win_high)
          s_nxt.m_acc = acc_put(s_r.m_acc, wlo + 3'h1, wbyte);
        else if (sfr == dsp_pkg::sfr_b)
          s_nxt.reg_b = wbyte;
        else if (sfr == dsp_pkg::sfr_opb_high)
          s_nxt.opb_high = wbyte;
        else if (sfr == dsp_pkg::sfr_status)
        begin
          s_nxt.carry = wbyte[dsp_pkg::st_carry];
          s_nxt.wrap = wbyte[dsp_pkg::st_wrap];
        end
        else if (sfr == dsp_pkg::sfr_cmd)
        begin
          // one-deep prefetch slot: the next byte queues while executing
          s_nxt.next_op = wbyte;
          s_nxt.next_valid = 1'b1;
        end
      end
    end

    case (s_r.st)
      st_idle:
      begin
        if (s_r.next_valid && s_r.next_op == dsp_pkg::prefix_ext)
        begin
          s_nxt.next_valid = 1'b0;
          s_nxt.st = st_prefix;
        end
        else if (s_r.next_valid)
        begin
          // any other byte here is treated as a byte multiply opcode
          s_nxt.next_valid = 1'b0;
          s_nxt.sop = sop_mul;
          s_nxt.cnt = dsp_pkg::mul_cycles - 4'h1;
          s_nxt.st = st_short;
        end
      end
      st_prefix:
      begin
        if (s_r.next_valid)
        begin
          s_nxt.next_valid = 1'b0;
          s_nxt.st = st_short;
          s_nxt.cnt = dsp_pkg::shift_cycles - 4'h2;
          if (s_r.next_op == dsp_pkg::op_mac)
          begin
            s_nxt.st = st_mac;
            s_nxt.cnt = 4'h0;
            s_nxt.prod = '0;
          end
          else if (s_r.next_op == dsp_pkg::op_clear_acc_op)
          begin
            s_nxt.sop = sop_clr;
            s_nxt.cnt = dsp_pkg::clr_cycles - 4'h2;
          end
          else if (s_r.next_op == dsp_pkg::op_shift_left_op)
            s_nxt.sop = sop_lsl;
          else if (s_r.next_op == dsp_pkg::op_asr_m)
            s_nxt.sop = sop_asr;
          else
            s_nxt.st = st_idle;
        end
      end
      st_mac:
      begin
        // steps 0..3 accumulate shifted partial products, operands untouched
        s_nxt.cnt = s_r.cnt + 4'h1;
        if (s_r.cnt < 4'h4)
          s_nxt.prod = s_r.prod +
            (40'(signed'(mprod)) << pp_sh);
        else if (s_r.cnt == dsp_pkg::mac_cycles - 4'h3)
        begin
          s_nxt.m_acc = sum;
          s_nxt.carry = sum[39];
          // set only, after the status write above, so a same-cycle clear loses
          if (s_r.m_acc[39] == s_r.prod[39] && sum[39] != s_r.m_acc[39])
            s_nxt.wrap = 1'b1;
        end
        else if (s_r.cnt == dsp_pkg::mac_cycles - 4'h2)
          s_nxt.st = st_done;
      end
      st_short:
      begin
        if (s_r.cnt == 4'h0)
        begin
          case (s_r.sop)
            sop_clr: s_nxt.m_acc = '0;
            sop_lsl: s_nxt.m_acc = {s_r.m_acc[38:0], 1'b0};
            sop_asr: s_nxt.m_acc = {s_r.m_acc[39], s_r.m_acc[39:1]};
            // byte multiply shares the 8x8 unit with config signedness
            default: s_nxt.mul_res = mprod[15:0];
          endcase
          s_nxt.st = st_done;
        end
        else
          s_nxt.cnt = s_r.cnt - 4'h1;
      end
      st_done:
        s_nxt.st = st_idle;
      default:
        s_nxt.st = st_idle;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r <= '0;
      s_r.st <= st_idle;
      s_r.cfg <= dsp_pkg::dsp_config_rst;
      // keep the fuse synchroniser running so the mode is settled at release
      s_r.fuse_meta <= compat_fuse_i;
      s_r.fuse_sync <= s_r.fuse_meta;
    end
    else
      s_r <= s_nxt;
  end

  assign busy_o = (s_r.st != st_idle);
  assign ack_o = s_r.ack;
  assign dat_o = {24'h000000, s_r.rdata};
  // pointer logic lives elsewhere; these steer it
  assign ring_enable_ptr0_o = s_r.cfg[dsp_pkg::cfg_ring0];
  assign ring_enable_ptr1_o = s_r.cfg[dsp_pkg::cfg_ring1];
  assign code_index_disable_o = s_r.cfg[dsp_pkg::cfg_idx_dis];
  assign ptr1_redirect_b_o = s_r.cfg[dsp_pkg::cfg_redirect];
  // branch extra-cycle timing belongs to the sequencer outside
endmodule

// ===== dsp_pkg.sv
// Purpose: shared constants for the cpu mac / dsp execution datapath
// Assumes: 8-bit special function register space, wishbone byte address = sfr address * 4
// Notes: opcodes are second bytes after the extended 0xa5 prefix
package dsp_pkg;
  localparam logic [7:0] prefix_ext = 8'ha5;
  localparam logic [7:0] op_mac = 8'ha4;
  localparam logic [7:0] op_clear_acc_op = 8'he4;
  localparam logic [7:0] op_shift_left_op = 8'h23;
  localparam logic [7:0] op_asr_m = 8'h03;
  // sfr indices, byte address is index * 4
  localparam logic [7:0] sfr_acc = 8'he0;
  localparam logic [7:0] sfr_opa_high = 8'he1;
  localparam logic [7:0] sfr_dsp_config = 8'he2;
  localparam logic [7:0] sfr_win_low = 8'he4;
  localparam logic [7:0] sfr_win_high = 8'he5;
  localparam logic [7:0] sfr_b = 8'hf0;
  localparam logic [7:0] sfr_opb_high = 8'hf7;
  localparam logic [7:0] sfr_status = 8'hd0;
  localparam logic [7:0] sfr_cmd = 8'hc0;
  localparam logic [7:0] sfr_prod_low = 8'hc1;
  localparam logic [7:0] sfr_prod_high = 8'hc2;
  // dsp_config field positions
  localparam int cfg_win_msb = 7;
  localparam int cfg_win_lsb = 6;
  localparam int cfg_signed_b = 5;
  localparam int cfg_signed_a = 4;
  localparam int cfg_ring1 = 3;
  localparam int cfg_ring0 = 2;
  localparam int cfg_idx_dis = 1;
  localparam int cfg_redirect = 0;
  localparam logic [7:0] dsp_config_rst = 8'h00;
  // status word bits
  localparam int st_carry = 7;
  localparam int st_wrap = 2;
  // cycle counts
  localparam logic [3:0] mac_cycles = 4'h9;
  localparam logic [3:0] clr_cycles = 4'h2;
  localparam logic [3:0] shift_cycles = 4'h2;
  localparam logic [3:0] mul_cycles = 4'h2;
  localparam logic [3:0] compat_fetch_div = 4'h3;
  localparam logic [3:0] ext_fetch_mult = 4'h3;
  localparam logic [3:0] states_per_mcycle = 4'h6;
  localparam logic [3:0] osc_per_state = 4'h2;
  localparam logic [7:0] compat_mcycle_clks = 8'h0c;
endpackage

// ===== fetch_pacer.sv
// Purpose: fetch enable pacing for fast and compatibility timing modes
// Assumes: one fetch slot per clock in fast mode from internal memory
// Notes: compatibility pacing is independent of memory source
module fetch_pacer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic compat_i,
  input wire logic ext_mem_i,
  output logic fetch_en_o,
  output logic state_tick_o,
  output logic mcycle_end_o
);
  typedef struct packed {
    logic [3:0] div;
    logic [3:0] state_cnt;
    logic osc;
  } pacer_t;
  pacer_t s_r, s_nxt;
  logic [3:0] period;

  always_comb
  begin
    s_nxt = s_r;
    // compatibility: byte every 3 clocks, memory source does not matter
    if (compat_i)
      period = dsp_pkg::compat_fetch_div;
    else if (ext_mem_i)
      period = dsp_pkg::ext_fetch_mult;
    else
      period = 4'h1;
    if (s_r.div + 4'h1 >= period)
      s_nxt.div = 4'h0;
    else
      s_nxt.div = s_r.div + 4'h1;
    // divide-by-2 state clock, 6 states per machine cycle
    s_nxt.osc = ~s_r.osc;
    if (s_r.osc)
    begin
      if (s_r.state_cnt == dsp_pkg::states_per_mcycle - 4'h1)
        s_nxt.state_cnt = 4'h0;
      else
        s_nxt.state_cnt = s_r.state_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign fetch_en_o = (s_r.div == 4'h0);
  assign state_tick_o = s_r.osc;
  assign mcycle_end_o = s_r.osc && (s_r.state_cnt == dsp_pkg::states_per_mcycle - 4'h1);
endmodule

// ===== mult8.sv
// Purpose: 8x8 multiplier with per-operand sign selection
// Assumes: combinational, used for byte multiply and mac partial products
// Notes: result is the 18-bit signed product of the two sign-or-zero-extended 9-bit operands
module mult8 (
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic sa_i,
  input wire logic sb_i,
  output logic [17:0] p_o
);
  logic signed [8:0] ea;
  logic signed [8:0] eb;
  logic signed [17:0] pr;

  always_comb
  begin
    ea = {sa_i & a_i[7], a_i};
    eb = {sb_i & b_i[7], b_i};
    pr = ea * eb;
    p_o = pr;
  end
endmodule

// ===== mac_datapath_checker.sv
// Purpose: port-level timing checks for the mac datapath
// Assumes: one clock, sync active-high reset
// Notes: fuse and memory source only change while reset is held
module mac_datapath_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic compat_fuse_i,
  input wire logic ext_mem_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic fetch_en_o,
  input wire logic mcycle_end_o,
  input wire logic busy_o,
  input wire logic ring_enable_ptr0_o,
  input wire logic ring_enable_ptr1_o,
  input wire logic code_index_disable_o,
  input wire logic ptr1_redirect_b_o
);
  logic [3:0] gap_r;
  logic seen_r;
  logic cfg_wr;
  assign cfg_wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0]
    && adr_i[9:2] == dsp_pkg::sfr_dsp_config;
  // first machine-cycle end after reset only arms the gap count
  always_ff @(posedge clk_i)
  begin
    if (rst_i || mcycle_end_o)
    begin
      gap_r <= 4'h0;
      seen_r <= !rst_i;
    end
    else
    begin
      gap_r <= gap_r + 4'h1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  ack_take_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("access not answered one cycle after take");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  rdata_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  fast_fetch_a: assert property (!compat_fuse_i && !ext_mem_i |-> fetch_en_o)
    else $error("fast internal mode missed a fetch slot");
  ext_fetch_a: assert property (!compat_fuse_i && ext_mem_i && fetch_en_o
    |=> !fetch_en_o ##1 !fetch_en_o ##1 fetch_en_o)
    else $error("fast external fetch not every third clock");
  compat_fetch_a: assert property (compat_fuse_i && fetch_en_o
    |=> !fetch_en_o ##1 !fetch_en_o ##1 fetch_en_o)
    else $error("compatibility fetch not every third clock");
  mcycle_len_a: assert property (seen_r && compat_fuse_i
    |-> mcycle_end_o == (gap_r == 4'hb))
    else $error("machine cycle not twelve clocks");
  busy_bound_a: assert property ($rose(busy_o) |-> ##[1:20] !busy_o)
    else $error("instruction did not finish in time");
  cfg_out_a: assert property (cfg_wr |=> {ring_enable_ptr1_o, ring_enable_ptr0_o,
    code_index_disable_o, ptr1_redirect_b_o} == $past(dat_i[3:0]))
    else $error("config outputs do not follow write");
  cfg_hold_a: assert property (!cfg_wr |=> $stable({ring_enable_ptr1_o,
    ring_enable_ptr0_o, code_index_disable_o, ptr1_redirect_b_o}))
    else $error("config outputs changed without write");
endmodule
bind mac_datapath mac_datapath_checker i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .compat_fuse_i(compat_fuse_i), .ext_mem_i(ext_mem_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .fetch_en_o(fetch_en_o), .mcycle_end_o(mcycle_end_o), .busy_o(busy_o),
  .ring_enable_ptr0_o(ring_enable_ptr0_o), .ring_enable_ptr1_o(ring_enable_ptr1_o),
  .code_index_disable_o(code_index_disable_o), .ptr1_redirect_b_o(ptr1_redirect_b_o));

// ===== mac_datapath_tb.sv
// Purpose: self-checking bench for the mac datapath
// Assumes: wishbone slave answers one cycle after take
// Notes: accumulator model is a plain 40-bit vector
module mac_datapath_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, compat_fuse_i, ext_mem_i, cyc_i, stb_i, we_i, ack_o;
  logic fetch_en_o, mcycle_end_o, busy_o, rp0, rp1, idx_dis, redir;
  logic [9:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, r;
  logic [39:0] m_acc;
  logic [15:0] x, y, p16;
  logic [7:0] q, cfg_m;
  logic wrap_m, carry_m;
  int failures = 0;
  int total_checks = 0;
  int seed = 32'h494f;
  int n;
  mac_datapath i_dut (.clk_i(clk_i), .rst_i(rst_i), .compat_fuse_i(compat_fuse_i),
    .ext_mem_i(ext_mem_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .fetch_en_o(fetch_en_o),
    .mcycle_end_o(mcycle_end_o), .busy_o(busy_o), .ring_enable_ptr0_o(rp0),
    .ring_enable_ptr1_o(rp1), .code_index_disable_o(idx_dis), .ptr1_redirect_b_o(redir));
  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // one classic cycle; the leading edge keeps cyc low a cycle between accesses
  task automatic wb(input logic [7:0] idx, input logic w, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h0, d};
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack_o !== 1'b1 && k < 20);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (k >= 20)
    begin
      failures++;
      final_report();
    end
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [7:0] m = 8'hff);
    wb(idx, 1'b0, 8'h00);
    chk(40'(q & m), 40'(e & m), "register read");
  endtask
  task automatic setcfg(input logic [7:0] v);
    wb(dsp_pkg::sfr_dsp_config, 1'b1, v);
    cfg_m = v;
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    // busy only rises the cycle after the command byte is taken
    @(posedge clk_i);
    while (busy_o !== 1'b0 && k < 40)
    begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 40)
    begin
      failures++;
      final_report();
    end
  endtask
  task automatic op(input logic [7:0] c);
    wb(dsp_pkg::sfr_cmd, 1'b1, dsp_pkg::prefix_ext);
    wb(dsp_pkg::sfr_cmd, 1'b1, c);
    wait_idle();
  endtask
  task automatic mac_model(input logic [15:0] a, input logic [15:0] b);
    logic [39:0] p, s;
    p = {{24{a[15]}}, a} * {{24{b[15]}}, b};
    s = m_acc + p;
    if (m_acc[39] == p[39] && s[39] != m_acc[39])
    begin
      wrap_m = 1'b1;
    end
    carry_m = s[39];
    m_acc = s;
  endtask
  // window 2 is skipped on load: windows 3 and 1 already cover its bytes
  task automatic set_acc(input logic [39:0] v);
    int w;
    m_acc = v;
    for (int j = 0; j < 3; j++)
    begin
      w = (j == 0) ? 3 : 2 - j;
      setcfg({2'(w), cfg_m[5:0]});
      wb(dsp_pkg::sfr_win_high, 1'b1, v[w*8+8 +: 8]);
      wb(dsp_pkg::sfr_win_low, 1'b1, v[w*8 +: 8]);
    end
  endtask
  task automatic chk_acc();
    for (int w = 0; w < 4; w++)
    begin
      setcfg({2'(w), cfg_m[5:0]});
      rd(dsp_pkg::sfr_win_high, m_acc[w*8+8 +: 8]);
      rd(dsp_pkg::sfr_win_low, m_acc[w*8 +: 8]);
    end
  endtask
  task automatic load_ops(input logic [31:0] v);
    wb(dsp_pkg::sfr_acc, 1'b1, v[7:0]);
    wb(dsp_pkg::sfr_opa_high, 1'b1, v[15:8]);
    wb(dsp_pkg::sfr_b, 1'b1, v[23:16]);
    wb(dsp_pkg::sfr_opb_high, 1'b1, v[31:24]);
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial
  begin
    {rst_i, sel_i, compat_fuse_i, ext_mem_i, cyc_i, stb_i, we_i} = 10'b1000100000;
    adr_i = 10'h000;
    dat_i = 32'h0;
    {m_acc, wrap_m, carry_m, cfg_m} = '0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(dsp_pkg::sfr_dsp_config, dsp_pkg::dsp_config_rst);
    chk_acc();
    rd(8'h10, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      r = $random(seed);
      setcfg(r[7:0]);
      rd(dsp_pkg::sfr_dsp_config, r[7:0]);
      chk(40'({rp1, rp0, idx_dis, redir}), 40'(r[3:0]), "config pins");
    end
    wb(dsp_pkg::sfr_status, 1'b1, 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      r = $random(seed);
      if (i == 5)
      begin
        set_acc(40'h7fffffffff);
        r = 32'h7fff7fff;
      end
      setcfg({r[7:4], 4'h0});
      load_ops(r);
      op(dsp_pkg::op_mac);
      mac_model(r[15:0], r[31:16]);
      rd(dsp_pkg::sfr_acc, r[7:0]);
      rd(dsp_pkg::sfr_opa_high, r[15:8]);
      rd(dsp_pkg::sfr_b, r[23:16]);
      rd(dsp_pkg::sfr_opb_high, r[31:24]);
      rd(dsp_pkg::sfr_status, {carry_m, 4'h0, wrap_m, 2'h0}, 8'h84);
      chk_acc();
    end
    op(dsp_pkg::op_asr_m);
    m_acc = {m_acc[39], m_acc[39:1]};
    chk_acc();
    op(dsp_pkg::op_shift_left_op);
    m_acc = {m_acc[38:0], 1'b0};
    chk_acc();
    op(dsp_pkg::op_clear_acc_op);
    m_acc = 40'h0;
    chk_acc();
    for (int k = 0; k < 4; k++)
    begin
      r = $random(seed);
      setcfg({2'h0, 2'(k), 4'h0});
      wb(dsp_pkg::sfr_acc, 1'b1, r[7:0]);
      wb(dsp_pkg::sfr_b, 1'b1, r[15:8]);
      wb(dsp_pkg::sfr_cmd, 1'b1, 8'ha4);
      wait_idle();
      x = k[0] ? {{8{r[7]}}, r[7:0]} : {8'h0, r[7:0]};
      y = k[1] ? {{8{r[15]}}, r[15:8]} : {8'h0, r[15:8]};
      p16 = x * y;
      rd(dsp_pkg::sfr_prod_low, p16[7:0]);
      rd(dsp_pkg::sfr_prod_high, p16[15:8]);
    end
    // mode pins only move under reset, so pacing restarts cleanly
    for (int md = 0; md < 3; md++)
    begin
      rst_i <= 1'b1;
      compat_fuse_i <= (md == 1);
      ext_mem_i <= (md != 0);
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      n = 0;
      repeat (36)
      begin
        @(posedge clk_i);
        n += int'(fetch_en_o);
      end
      chk(40'(n), (md == 0) ? 40'd36 : 40'd12, "fetch slots");
    end
    final_report();
  end
endmodule
